//--- hw/tls_defs.svh
// Register offsets, field positions and reset values of the per-link register slice.
`ifndef TLS_DEFS_SVH
`define TLS_DEFS_SVH

// ----------------------------------------------------------------
// Register indices within one link (byte address = 4 * index)
// ----------------------------------------------------------------
`define TLS_OFS_IRQ_STAT1 8'h3b
`define TLS_OFS_CNT_HI 8'h3c
`define TLS_OFS_CNT_LO 8'h3d
`define TLS_OFS_REFCTL 8'h3e
`define TLS_OFS_IND_LI 8'h3f
`define TLS_OFS_IND_FR 8'h40
`define TLS_OFS_IND_DL 8'h41
`define TLS_OFS_TXOPT 8'h42

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TLS_BIT_OVF 0
`define TLS_BIT_HOLD 0
`define TLS_BIT_LIU 0
`define TLS_BIT_GAP 5
`define TLS_BIT_DE 4
`define TLS_BIT_FE 3
`define TLS_BIT_CMS 2
`define TLS_BIT_FRAME_PULSE_POLARITY 1
`define TLS_BIT_FRAME_PULSE_TYPE 0
`define TLS_TXOPT_W 6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TLS_RST_CNT 16'h0000
`define TLS_RST_BYTE 8'h00
`define TLS_RST_TXOPT 6'h00
`define TLS_RST_WORD 32'h0000_0000

`endif

//--- hw/tls_pkg.sv
// Shared types of the per-link register slice.
package tls_pkg;
    typedef logic [7:0] tls_byte_t;
    typedef logic [15:0] tls_count_t;
    typedef logic [11:0] tls_index_t;
endpackage

//--- hw/tls_regs.sv
// Per-link counter, reference-clock, interrupt indication and transmit option registers.
//
// Notes on behaviour
// - High byte register returns upper eight bits of the excess-zero counter, read only.
// - Low byte register at next offset returns lower counter byte latched by the last high byte read; both reset to zero.
// - Every register repeats per link; link number in index bits 11:8, stride 0x100.
// - During signal loss, reference outputs carry master clock, or high when hold bit set.
// - Line interface indication bit 0 is one while any line function interrupt pends.
// - Framer indication bits 7..0: loop code, message, alarm, monitor, PRBS, signaling, generator, processor.
// - Data link indication bits 7..5 transmitters 3..1, bits 4..2 receivers 3..1.
// - Bit 1 elastic store, bit 0 system interface; indications read only, reset zero.
// - Data edge bit: 0 falling, 1 rising edge samples transmit data and signaling.
// - Frame edge bit: 0 falling, 1 rising edge handles the framing pulse.
// - Clock speed bit in slave E1 rate or multiplexed mode: 0 equal, 1 double rate.
// - In clock master mode only, gap option stops transmit clock during each F-bit.
// - Counter wrap sets the overflow flag; software clears it by writing one.
// - Polarity bit: framing pulse active high when 0, active low when 1.
// - Type bit: pulse at every F-bit when 0, first F-bit of multiframe when 1.
//
// Decided for this implementation: the Wishbone register port.
`include "tls_defs.svh"

module tls_regs #(
    parameter int NL = 8 // Number of links.
) (
    input wire logic clk_in, // System clock, 10 MHz.
    input wire logic resetn_in, // Synchronous reset, active low.
    input wire logic link_clk_in, // Line-side clock of the error detectors.
    input wire logic link_resetn_in, // Synchronous reset of the line side, active low.
    input wire logic wb_cyc_in, // Wishbone cycle.
    input wire logic wb_stb_in, // Wishbone strobe.
    input wire logic wb_we_in, // Wishbone write enable.
    input wire logic [13:2] wb_adr_in, // Wishbone word address (register index).
    input wire logic [3:0] wb_sel_in, // Wishbone byte selects.
    input wire logic [31:0] wb_dat_in, // Wishbone write data.
    output logic [31:0] wb_dat_out, // Wishbone read data.
    output logic wb_ack_out, // Wishbone acknowledge.
    input wire logic [NL-1:0] excess_zero_in, // Excess-zero event pulses, link clock.
    input wire logic [NL-1:0] los_in, // Loss of signal levels, asynchronous.
    input wire logic mclk_in, // Master clock for the reference outputs.
    input wire logic [NL-1:0] ref_clk_in, // Normal reference clocks per link.
    output logic [NL-1:0] ref_output_a_out, // Reference output A per link.
    output logic [NL-1:0] ref_output_b_out, // Reference output B per link.
    input wire logic [NL-1:0] line_if_int_in, // Line interface pending interrupt.
    input wire logic [NL-1:0][7:0] framer_int_in, // Framer blocks pending interrupts.
    input wire logic [NL-1:0][7:0] datalink_int_in, // Data link blocks pending interrupts.
    input wire logic [NL-1:0] tx_master_mode_in, // Transmit clock master mode.
    input wire logic [NL-1:0] fbit_in, // Current bit is an F-bit.
    input wire logic [NL-1:0] fbit_first_in, // Current F-bit is first of its multiframe.
    output logic [NL-1:0] data_edge_sel_out, // 1 rising, 0 falling data sample edge.
    output logic [NL-1:0] frame_edge_sel_out, // 1 rising, 0 falling frame pulse edge.
    output logic [NL-1:0] clock_speed_sel_out, // 1 double, 0 equal clock rate.
    output logic [NL-1:0] tx_clock_enable_out, // Low gaps the transmit system clock.
    output logic [NL-1:0] tx_sys_frame_pulse_out, // Transmit framing pulse.
    output logic [NL-1:0] count_overflow_flag_out // Sticky counter overflow flags.
);
    import tls_pkg::*;

    if (NL < 1 || NL > 16) begin : g_chk
        $error("tls_regs: NL must lie between 1 and 16");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [NL-1:0] tgl;
    } tls_link_s;

    typedef struct packed {
        logic [NL-1:0] ez_s1;
        logic [NL-1:0] ez_s2;
        logic [NL-1:0] ez_s3;
        logic [NL-1:0] los_s1;
        logic [NL-1:0] los_s2;
        logic [NL-1:0][15:0] cnt;
        logic [NL-1:0][7:0] shadow;
        logic [NL-1:0] ovf;
        logic [NL-1:0] hold;
        logic [NL-1:0][`TLS_TXOPT_W-1:0] opt;
        logic [NL-1:0] ind_li;
        logic [NL-1:0][7:0] ind_fr;
        logic [NL-1:0][7:0] ind_dl;
        logic [NL-1:0] fp;
        logic ack;
        logic [31:0] dat;
    } tls_sys_s;

    tls_link_s lk_ff;
    tls_link_s nxt_lk;
    tls_sys_s st_ff;
    tls_sys_s nxt_st;

    // Index bits 11:8 carry the link, bits 7:0 the register within it.
    function automatic logic hit(input tls_index_t idx, input int l, input tls_byte_t ofs);
        hit = (idx[11:8] == 4'(l)) && (idx[7:0] == ofs);
    endfunction

    // ----------------------------------------------------------------
    // Line side: each event flips a toggle, which survives the crossing
    // ----------------------------------------------------------------
    always_comb begin
        nxt_lk = lk_ff;
        nxt_lk.tgl = lk_ff.tgl ^ excess_zero_in;
        if (!link_resetn_in) begin
            nxt_lk.tgl = '0;
        end
    end

    always_ff @(posedge link_clk_in) begin
        lk_ff <= nxt_lk;
    end

    // ----------------------------------------------------------------
    // System side
    // ----------------------------------------------------------------
    // Two events closer than one system clock on one link can cancel in the toggle and give no count;
    // the detectors run at line rate well below that.
    always_comb begin
        logic req;
        logic wr;
        logic rd;
        logic ev;
        tls_index_t idx;
        req = wb_cyc_in && wb_stb_in && !st_ff.ack;
        wr = req && wb_we_in && wb_sel_in[0];
        rd = req && !wb_we_in;
        ev = 1'b0;
        idx = wb_adr_in;
        nxt_st = st_ff;
        nxt_st.ez_s1 = lk_ff.tgl;
        nxt_st.ez_s2 = st_ff.ez_s1;
        nxt_st.ez_s3 = st_ff.ez_s2;
        nxt_st.los_s1 = los_in;
        nxt_st.los_s2 = st_ff.los_s1;
        nxt_st.ind_li = line_if_int_in;
        nxt_st.ind_fr = framer_int_in;
        nxt_st.ind_dl = datalink_int_in;
        nxt_st.ack = req;
        nxt_st.dat = `TLS_RST_WORD;
        for (int l = 0; l < NL; l++) begin
            ev = st_ff.ez_s2[l] ^ st_ff.ez_s3[l];
            if (ev) begin
                nxt_st.cnt[l] = 16'(st_ff.cnt[l] + 16'h0001);
            end
            if (wr && hit(idx, l, `TLS_OFS_IRQ_STAT1) && wb_dat_in[`TLS_BIT_OVF]) begin
                nxt_st.ovf[l] = 1'b0;
            end
            if (ev && st_ff.cnt[l] == 16'hffff) begin
                nxt_st.ovf[l] = 1'b1;
            end
            if (wr && hit(idx, l, `TLS_OFS_REFCTL)) begin
                nxt_st.hold[l] = wb_dat_in[`TLS_BIT_HOLD];
            end
            if (wr && hit(idx, l, `TLS_OFS_TXOPT)) begin
                nxt_st.opt[l] = wb_dat_in[`TLS_TXOPT_W-1:0];
            end
            if (rd && hit(idx, l, `TLS_OFS_CNT_HI)) begin
                nxt_st.shadow[l] = st_ff.cnt[l][7:0];
                nxt_st.dat[7:0] = st_ff.cnt[l][15:8];
            end
            if (rd && hit(idx, l, `TLS_OFS_CNT_LO)) begin
                nxt_st.dat[7:0] = st_ff.shadow[l];
            end
            if (rd && hit(idx, l, `TLS_OFS_IRQ_STAT1)) begin
                nxt_st.dat[`TLS_BIT_OVF] = st_ff.ovf[l];
            end
            if (rd && hit(idx, l, `TLS_OFS_REFCTL)) begin
                nxt_st.dat[`TLS_BIT_HOLD] = st_ff.hold[l];
            end
            if (rd && hit(idx, l, `TLS_OFS_IND_LI)) begin
                nxt_st.dat[`TLS_BIT_LIU] = st_ff.ind_li[l];
            end
            if (rd && hit(idx, l, `TLS_OFS_IND_FR)) begin
                nxt_st.dat[7:0] = st_ff.ind_fr[l];
            end
            if (rd && hit(idx, l, `TLS_OFS_IND_DL)) begin
                nxt_st.dat[7:0] = st_ff.ind_dl[l];
            end
            if (rd && hit(idx, l, `TLS_OFS_TXOPT)) begin
                nxt_st.dat[`TLS_TXOPT_W-1:0] = st_ff.opt[l];
            end
            // Type picks every F-bit or only the first; polarity then inverts.
            nxt_st.fp[l] = (fbit_in[l] && (!st_ff.opt[l][`TLS_BIT_FRAME_PULSE_TYPE] || fbit_first_in[l]))
                ^ st_ff.opt[l][`TLS_BIT_FRAME_PULSE_POLARITY];
        end
        if (!resetn_in) begin
            nxt_st = '0;
            nxt_st.cnt = {NL{`TLS_RST_CNT}};
            nxt_st.shadow = {NL{`TLS_RST_BYTE}};
            nxt_st.opt = {NL{`TLS_RST_TXOPT}};
            nxt_st.ind_fr = {NL{`TLS_RST_BYTE}};
            nxt_st.ind_dl = {NL{`TLS_RST_BYTE}};
            nxt_st.dat = `TLS_RST_WORD;
        end
    end

    always_ff @(posedge clk_in) begin
        st_ff <= nxt_st;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign wb_ack_out = st_ff.ack;
    assign wb_dat_out = st_ff.dat;
    assign count_overflow_flag_out = st_ff.ovf;
    assign tx_sys_frame_pulse_out = st_ff.fp;

    always_comb begin
        for (int l = 0; l < NL; l++) begin
            data_edge_sel_out[l] = st_ff.opt[l][`TLS_BIT_DE];
            frame_edge_sel_out[l] = st_ff.opt[l][`TLS_BIT_FE];
            clock_speed_sel_out[l] = st_ff.opt[l][`TLS_BIT_CMS];
            // Gating is only honoured in master mode; in slave mode the clock comes from outside.
            tx_clock_enable_out[l] = !(tx_master_mode_in[l] && fbit_in[l]
                && st_ff.opt[l][`TLS_BIT_GAP]);
            // This clock mux is not glitch free; a switch on loss may leave one short pulse.
            if (st_ff.los_s2[l]) begin
                ref_output_a_out[l] = st_ff.hold[l] ? 1'b1 : mclk_in;
            end else begin
                ref_output_a_out[l] = ref_clk_in[l];
            end
            ref_output_b_out[l] = ref_output_a_out[l];
        end
    end
endmodule

//--- verif/tls_regs_chk.sv
// Concurrent checks on the ports of the per-link register slice.
module tls_regs_chk #(
    parameter int NL = 8
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [13:2] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    input wire logic [NL-1:0] ref_output_a_out,
    input wire logic [NL-1:0] ref_output_b_out,
    input wire logic [NL-1:0][7:0] framer_int_in,
    input wire logic [NL-1:0] tx_master_mode_in,
    input wire logic [NL-1:0] fbit_in,
    input wire logic [NL-1:0] tx_clock_enable_out,
    input wire logic [NL-1:0] data_edge_sel_out,
    input wire logic [NL-1:0] frame_edge_sel_out,
    input wire logic [NL-1:0] clock_speed_sel_out,
    input wire logic [NL-1:0] count_overflow_flag_out
);
    // ----------------------------------------------------------------
    // Bus, register and output checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_req;
        wb_cyc_in && wb_stb_in && !wb_ack_out;
    endsequence
    sequence s_wr_opt;
        wb_cyc_in && wb_stb_in && !wb_ack_out && wb_we_in && wb_sel_in[0] && wb_adr_in == 12'h042;
    endsequence
    AST_ACK_NEXT: assert property (s_req |=> wb_ack_out)
        else $error("request not acknowledged in the next cycle");
    AST_ACK_PULSE: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("acknowledge longer than one cycle");
    AST_ACK_CAUSE: assert property ($rose(wb_ack_out) |-> $past(wb_cyc_in && wb_stb_in))
        else $error("acknowledge without a request");
    AST_RD_UPPER: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    AST_REF_SAME: assert property (ref_output_a_out == ref_output_b_out)
        else $error("reference outputs differ");
    AST_GAP_CAUSE: assert property (&(tx_clock_enable_out | (tx_master_mode_in & fbit_in)))
        else $error("transmit clock gapped outside master F-bit");
    AST_OPT_WR: assert property (s_wr_opt |-> ##[1:2]
        {data_edge_sel_out[0], frame_edge_sel_out[0], clock_speed_sel_out[0]} == wb_dat_in[4:2])
        else $error("option write not reflected on the select outputs");
    AST_OVF_CLR: assert property ($fell(count_overflow_flag_out[0]) |->
        $past(wb_cyc_in && wb_stb_in && wb_we_in && wb_adr_in == 12'h03b && wb_dat_in[0]))
        else $error("overflow flag cleared without a write of one");
    AST_IND_RD: assert property (wb_ack_out && !wb_we_in && wb_adr_in == 12'h040 &&
        $past(framer_int_in[0]) == framer_int_in[0] && $past(framer_int_in[0], 2) == framer_int_in[0]
        |-> wb_dat_out[7:0] == framer_int_in[0])
        else $error("framer indication read differs from pending levels");
endmodule
bind tls_regs tls_regs_chk #(.NL(NL)) u_tls_regs_chk (.*);

//--- verif/tls_regs_tb_top.sv
// Self-checking bench of the per-link register slice.
module tls_regs_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import tls_pkg::*;
    logic clk_in = 0, resetn_in = 0, link_clk_in = 0, link_resetn_in = 0, mclk_in = 0;
    logic wb_cyc_in = 0, wb_stb_in = 0, wb_we_in = 0, wb_ack_out;
    logic [11:0] wb_adr_in = '0;
    logic [3:0] wb_sel_in = 4'h1;
    logic [31:0] wb_dat_in = '0, wb_dat_out;
    logic [7:0] excess_zero_in = '0, los_in = '0, ref_clk_in = '0, line_if_int_in = '0;
    logic [7:0] tx_master_mode_in = '0, fbit_in = '0, fbit_first_in = '0;
    logic [7:0][7:0] framer_int_in = '0, datalink_int_in = '0;
    logic [7:0] ref_output_a_out, ref_output_b_out, data_edge_sel_out, frame_edge_sel_out;
    logic [7:0] clock_speed_sel_out, tx_clock_enable_out, tx_sys_frame_pulse_out;
    logic [7:0] count_overflow_flag_out;
    int err_total = 0, comparisons = 0, cycles = 0;
    tls_byte_t q;
    // Row fields: write flag, register index, write data, expected read data.
    logic [28:0] rows [17] = '{
        {1'b0, 12'h03c, 16'h0000}, {1'b0, 12'h03d, 16'h0000}, {1'b0, 12'h03e, 16'h0000},
        {1'b0, 12'h040, 16'h0000}, {1'b0, 12'h041, 16'h0000}, {1'b0, 12'h042, 16'h0000},
        {1'b1, 12'h042, 16'hff00}, {1'b0, 12'h042, 16'h003f}, {1'b1, 12'h142, 16'h1500},
        {1'b0, 12'h142, 16'h0015}, {1'b0, 12'h042, 16'h003f}, {1'b1, 12'h040, 16'hff00},
        {1'b0, 12'h040, 16'h0000}, {1'b1, 12'h03e, 16'h0100}, {1'b0, 12'h03e, 16'h0001},
        {1'b0, 12'h842, 16'h0000}, {1'b0, 12'h0ff, 16'h0000}};

    tls_regs u_tls_regs (.*);

    initial forever #50 clk_in = ~clk_in;
    initial begin
        #7;
        forever #15 link_clk_in = ~link_clk_in;
    end
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input tls_byte_t got, input tls_byte_t exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Entered just after a clock edge; the request stands until ack is sampled.
    task automatic wb(input logic we, input logic [11:0] a, input tls_byte_t d);
        int n;
        n = 0;
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= we;
        wb_adr_in <= a;
        wb_dat_in <= {24'h0, d};
        do begin
            @(posedge clk_in);
            n++;
        end while (wb_ack_out !== 1'b1 && n < 20);
        if (wb_ack_out !== 1'b1) begin
            err_total++;
            $display("[FAIL] t=%0t ack=%h exp=%h", $time, wb_ack_out, 1'b1);
        end
        q = wb_dat_out[7:0];
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [11:0] a, input tls_byte_t e);
        wb(1'b0, a, 8'h00);
        chk(q, e);
    endtask
    task automatic pulse();
        @(posedge link_clk_in);
        excess_zero_in <= 8'h01;
        @(posedge link_clk_in);
        excess_zero_in <= 8'h00;
        repeat (12) @(posedge link_clk_in);
        @(posedge clk_in);
    endtask

    initial begin
        repeat (10) @(posedge clk_in);
        resetn_in <= 1'b1;
        link_resetn_in <= 1'b1;
        @(posedge clk_in);
        // Links run non-multiplexed with their own clocks, so differing options are legal.
        for (int i = 0; i < 17; i++) begin
            if (rows[i][28])
                wb(1'b1, rows[i][27:16], rows[i][15:8]);
            else
                rd(rows[i][27:16], rows[i][7:0]);
        end
        $display("test register rows done");
        framer_int_in <= 64'h5aa5;
        datalink_int_in <= 64'h03fc;
        line_if_int_in <= 8'h02;
        repeat (2) @(posedge clk_in);
        rd(12'h040, 8'ha5);
        rd(12'h140, 8'h5a);
        rd(12'h041, 8'hfc);
        rd(12'h141, 8'h03);
        rd(12'h03f, 8'h00);
        rd(12'h13f, 8'h01);
        framer_int_in <= '0;
        repeat (2) @(posedge clk_in);
        rd(12'h040, 8'h00);
        $display("test indications done");
        repeat (257) pulse();
        rd(12'h03c, 8'h01);
        pulse();
        rd(12'h03d, 8'h01);
        rd(12'h03c, 8'h01);
        rd(12'h03d, 8'h02);
        rd(12'h03b, 8'h00);
        wb(1'b1, 12'h03b, 8'h01);
        chk(count_overflow_flag_out, 8'h00);
        $display("test counter done");
        los_in <= 8'h03;
        repeat (4) @(posedge clk_in);
        chk(ref_output_a_out, 8'h01);
        mclk_in <= 1'b1;
        @(posedge clk_in);
        chk(ref_output_b_out, 8'h03);
        wb(1'b1, 12'h03e, 8'h00);
        mclk_in <= 1'b0;
        @(posedge clk_in);
        chk(ref_output_a_out, 8'h00);
        $display("test reference outputs done");
        tx_master_mode_in <= 8'h01;
        fbit_in <= 8'hff;
        repeat (2) @(posedge clk_in);
        chk(tx_clock_enable_out, 8'hfe);
        chk(tx_sys_frame_pulse_out, 8'hfd);
        chk(data_edge_sel_out, 8'h03);
        chk(frame_edge_sel_out, 8'h01);
        chk(clock_speed_sel_out, 8'h03);
        fbit_first_in <= 8'hff;
        repeat (2) @(posedge clk_in);
        chk(tx_sys_frame_pulse_out, 8'hfe);
        $display("test transmit options done");
        resetn_in <= 1'b0;
        link_resetn_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        resetn_in <= 1'b1;
        link_resetn_in <= 1'b1;
        @(posedge clk_in);
        rd(12'h042, 8'h00);
        rd(12'h03c, 8'h00);
        $display("test mid-run reset done");
        wrap_up();
    end
endmodule
